/* File: verilog/bosc_pkg.sv */
// constants for the bit-op, skip and call execution block
// assumes 12-bit instruction words and an 11-bit program counter
package bosc_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int INSTR_W   = 12;
   localparam int PC_W      = 11;
   localparam int DATA_W    = 8;
   localparam int FADDR_W   = 5;
   localparam int BIT_W     = 3;
   localparam int LIT_W     = 8;
   localparam int OPC_W     = 4;

   // ***************************************************************
   // instruction field positions
   // ***************************************************************
   localparam int OPC_LSB   = 8;
   localparam int BIT_LSB   = 5;
   localparam int FADDR_LSB = 0;
   localparam int LIT_LSB   = 0;

   // ***************************************************************
   // opcodes in the top nibble
   // ***************************************************************
   localparam logic [OPC_W-1:0] OPC_BIT_SET   = 4'h5;
   localparam logic [OPC_W-1:0] OPC_SKIP_ZERO = 4'h6;
   localparam logic [OPC_W-1:0] OPC_SKIP_ONE  = 4'h7;
   localparam logic [OPC_W-1:0] OPC_CALL      = 4'h9;

   // ***************************************************************
   // call target forming
   // ***************************************************************
   localparam int STATUS_PAGE_LSB = 5;
   localparam int PC_PAGE_LSB     = 9;
   localparam int PAGE_W          = 2;
   localparam int PC_ZERO_BIT     = 8;
   localparam int STACK_DEPTH     = 2;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [PC_W-1:0]   PC_RST   = 11'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   typedef enum logic [0:0] {
      BOSC_EXEC     = 1'b0,
      BOSC_NOP_SLOT = 1'b1
   } bosc_state_type;

endpackage

/* File: verilog/bosc_stack.sv */
// return address stack, pushed by the call path
// assumes pop comes from the return logic outside this block
`timescale 1ns/100ps
module bosc_stack #(
   parameter int WIDTH = bosc_pkg::PC_W,
   parameter int DEPTH = bosc_pkg::STACK_DEPTH
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             push_i,
   input  wire logic             pop_i,
   input  wire logic [WIDTH-1:0] push_data_i,
   output logic      [WIDTH-1:0] top_o
);
   import bosc_pkg::*;

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];

   // refuse sizes the shift logic cannot hold, at elaboration
   if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
      $error("bosc_stack: bad depth or width");
   end

   // ***************************************************************
   // shift stack: overflow silently drops the oldest entry
   // ***************************************************************
   always_comb begin
      next_mem = mem;
      if (push_i) begin
         next_mem[0] = push_data_i;
         for (int i = 1; i < DEPTH; i++) begin
            next_mem[i] = mem[i-1];
         end
      end else if (pop_i) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_mem[i] = mem[i+1];
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         mem <= next_mem;
      end
   end

   assign top_o = mem[0];

endmodule

/* File: verilog/bosc_exec.sv */
// execution of bit set, bit test and skip, and subroutine call
// assumes a register file with combinational read and a fetch unit
// that honours instr_ready_o, discard_o and pc_load_o
//
// What this block does
// - bit set forces bit b of f
// - skip next when tested bit is one
// - skip-if-one skip: no-operation slot, two cycles
// - skip next when tested bit is zero
// - skip-if-zero skip: no-operation slot, two cycles
// - call pushes program counter plus one
// - call loads literal into pc low bits
// - call pc page from status, bit8 zero
// - call takes two instruction cycles
`timescale 1ns/100ps
module bosc_exec (
   input  wire logic                           clk_i,
   input  wire logic                           arst_n_i,
   input  wire logic [bosc_pkg::INSTR_W-1:0]   instr_i,
   input  wire logic                           instr_valid_i,
   output logic                                instr_ready_o,
   input  wire logic [bosc_pkg::PC_W-1:0]      pc_i,
   input  wire logic [bosc_pkg::DATA_W-1:0]    status_i,
   output logic      [bosc_pkg::FADDR_W-1:0]   rf_raddr_o,
   input  wire logic [bosc_pkg::DATA_W-1:0]    rf_rdata_i,
   output logic                                rf_we_o,
   output logic      [bosc_pkg::FADDR_W-1:0]   rf_waddr_o,
   output logic      [bosc_pkg::DATA_W-1:0]    rf_wdata_o,
   output logic                                status_we_o,
   output logic                                discard_o,
   output logic                                pc_load_o,
   output logic      [bosc_pkg::PC_W-1:0]      pc_target_o,
   input  wire logic                           stack_pop_i,
   output logic      [bosc_pkg::PC_W-1:0]      stack_top_o
);
   import bosc_pkg::*;

   function automatic logic bit_of(input logic [DATA_W-1:0] d, input logic [BIT_W-1:0] b);
      bit_of = d[b];
   endfunction

   function automatic logic [DATA_W-1:0] set_bit(input logic [DATA_W-1:0] d,
                                                  input logic [BIT_W-1:0]  b);
      set_bit    = d;
      set_bit[b] = 1'b1;
   endfunction

   bosc_state_type            state;
   bosc_state_type            next_state;
   logic                      next_rf_we;
   logic [FADDR_W-1:0]        next_rf_waddr;
   logic [DATA_W-1:0]         next_rf_wdata;
   logic                      next_pc_load;
   logic [PC_W-1:0]           next_pc_target;
   logic                      next_status_we;
   logic                      accept;
   logic                      push;
   logic [OPC_W-1:0]          opc;
   logic [BIT_W-1:0]          bsel;
   logic [FADDR_W-1:0]        faddr;
   logic [LIT_W-1:0]          lit;
   logic                      tested;

   assign opc        = instr_i[OPC_LSB +: OPC_W];
   assign bsel       = instr_i[BIT_LSB +: BIT_W];
   assign faddr      = instr_i[FADDR_LSB +: FADDR_W];
   assign lit        = instr_i[LIT_LSB +: LIT_W];
   assign rf_raddr_o = faddr;
   assign tested     = bit_of(rf_rdata_i, bsel);

   // no new word is taken while the discarded slot runs
   assign instr_ready_o = (state == BOSC_EXEC);
   assign accept        = instr_valid_i && instr_ready_o;
   assign discard_o     = (state == BOSC_NOP_SLOT);

   // ***************************************************************
   // decode and next values
   // ***************************************************************
   always_comb begin
      next_state     = BOSC_EXEC;
      next_rf_we     = 1'b0;
      next_rf_waddr  = rf_waddr_o;
      next_rf_wdata  = rf_wdata_o;
      next_pc_load   = 1'b0;
      next_pc_target = pc_target_o;
      next_status_we = 1'b0;
      push           = 1'b0;
      if (accept) begin
         case (opc)
            OPC_BIT_SET: begin
               next_rf_we    = 1'b1;
               next_rf_waddr = faddr;
               next_rf_wdata = set_bit(rf_rdata_i, bsel);
            end
            OPC_SKIP_ONE: begin
               if (tested) begin
                  next_state = BOSC_NOP_SLOT;
               end
            end
            OPC_SKIP_ZERO: begin
               if (!tested) begin
                  next_state = BOSC_NOP_SLOT;
               end
            end
            OPC_CALL: begin
               push           = 1'b1;
               next_pc_load   = 1'b1;
               next_pc_target = {status_i[STATUS_PAGE_LSB +: PAGE_W], 1'b0, lit};
               next_state     = BOSC_NOP_SLOT;
            end
            default: begin
               next_state = BOSC_EXEC;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state       <= BOSC_EXEC;
         rf_we_o     <= 1'b0;
         rf_waddr_o  <= '0;
         rf_wdata_o  <= DATA_RST;
         pc_load_o   <= 1'b0;
         pc_target_o <= PC_RST;
         status_we_o <= 1'b0;
      end else begin
         state       <= next_state;
         rf_we_o     <= next_rf_we;
         rf_waddr_o  <= next_rf_waddr;
         rf_wdata_o  <= next_rf_wdata;
         pc_load_o   <= next_pc_load;
         pc_target_o <= next_pc_target;
         status_we_o <= next_status_we;
      end
   end

   // ***************************************************************
   // return stack
   // ***************************************************************
   bosc_stack #(
      .WIDTH (PC_W),
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .push_i      (push),
      .pop_i       (stack_pop_i),
      .push_data_i (PC_W'(pc_i + 1'b1)),
      .top_o       (stack_top_o)
   );

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_bit_set;
      accept && opc == OPC_BIT_SET |=> rf_we_o && rf_waddr_o == $past(faddr)
         && rf_wdata_o == ($past(rf_rdata_i) | (8'h01 << $past(bsel)));
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

   property p_skip_one;
      accept && opc == OPC_SKIP_ONE |=> discard_o == $past(tested);
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("skip if one wrong");

   property p_skip_one_len;
      accept && opc == OPC_SKIP_ONE && tested |=> !instr_ready_o ##1 instr_ready_o;
   endproperty
   a_skip_one_len: assert property (p_skip_one_len) else $error("skip slot length");

   property p_skip_zero;
      accept && opc == OPC_SKIP_ZERO |=> discard_o == !$past(tested);
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("skip if zero wrong");

   property p_skip_zero_len;
      accept && opc == OPC_SKIP_ZERO && !tested |=> discard_o ##1 !discard_o;
   endproperty
   a_skip_zero_len: assert property (p_skip_zero_len) else $error("zero slot len");

   property p_call_push;
      accept && opc == OPC_CALL |=> stack_top_o == PC_W'($past(pc_i) + 1'b1);
   endproperty
   a_call_push: assert property (p_call_push) else $error("return address wrong");

   property p_call_low;
      accept && opc == OPC_CALL |=> pc_load_o && pc_target_o[7:0] == $past(lit);
   endproperty
   a_call_low: assert property (p_call_low) else $error("call low bits wrong");

   property p_call_page;
      accept && opc == OPC_CALL |=> !pc_target_o[PC_ZERO_BIT]
         && pc_target_o[10:9] == $past(status_i[6:5]);
   endproperty
   a_call_page: assert property (p_call_page) else $error("call page wrong");

   property p_call_len;
      accept && opc == OPC_CALL |=> (!instr_ready_o && discard_o) ##1 instr_ready_o;
   endproperty
   a_call_len: assert property (p_call_len) else $error("call length wrong");

   property p_no_status;
      !status_we_o;
   endproperty
   a_no_status: assert property (p_no_status) else $error("status written");

   c_set:   cover property (accept && opc == OPC_BIT_SET);
   c_skip1: cover property (accept && opc == OPC_SKIP_ONE && tested);
   c_skip0: cover property (accept && opc == OPC_SKIP_ZERO && !tested);
   c_call:  cover property (accept && opc == OPC_CALL ##2 accept && opc == OPC_CALL);

endmodule

/* File: dv/bosc_rf_model.sv */
// register file model on the far side of the execution block
// assumes the bench preloads mem before the first instruction
`timescale 1ns/100ps
module bosc_rf_model
   import bosc_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic [FADDR_W-1:0] raddr_i,
   input  wire logic               we_i,
   input  wire logic [FADDR_W-1:0] waddr_i,
   input  wire logic [DATA_W-1:0]  wdata_i,
   output logic      [DATA_W-1:0]  rdata_o
);
   // *********************************************
   // storage
   // *********************************************
   logic [DATA_W-1:0] mem [32];

   // same-cycle read, the bit tests rely on it
   assign rdata_o = mem[raddr_i];

   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
endmodule

/* File: dv/bosc_exec_bench.sv */
// self-checking bench for the bit-op, skip and call execution block
// assumes one 40 MHz clock and the register file model beside it
`timescale 1ns/100ps
module bosc_exec_bench;
   import bosc_pkg::*;
   logic                 clk_i = 1'b0;
   logic                 arst_n_i = 1'b0;
   logic                 instr_valid_i = 1'b0;
   logic                 stack_pop_i = 1'b0;
   logic [INSTR_W-1:0]   instr_i = '0;
   logic [PC_W-1:0]      pc_i = '0;
   logic [DATA_W-1:0]    status_i = '0;
   logic [DATA_W-1:0]    rf_rdata_i;
   logic                 instr_ready_o;
   logic [FADDR_W-1:0]   rf_raddr_o;
   logic                 rf_we_o;
   logic [FADDR_W-1:0]   rf_waddr_o;
   logic [DATA_W-1:0]    rf_wdata_o;
   logic                 status_we_o;
   logic                 discard_o;
   logic                 pc_load_o;
   logic [PC_W-1:0]      pc_target_o;
   logic [PC_W-1:0]      stack_top_o;
   logic [DATA_W-1:0]    shadow [32];
   logic [25:0]          expq [$];
   logic [25:0]          got;
   logic [PC_W-1:0]      ret_new = '0;
   logic [PC_W-1:0]      ret_old = '0;
   logic [OPC_W-1:0]     opc_tab [5] = '{OPC_BIT_SET, OPC_SKIP_ZERO, OPC_SKIP_ONE,
                                         OPC_CALL, 4'ha};
   int                   errors = 0;
   int                   n_compared = 0;

   bosc_exec bosc_exec_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .pc_i(pc_i),
      .status_i(status_i), .rf_raddr_o(rf_raddr_o), .rf_rdata_i(rf_rdata_i),
      .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o),
      .status_we_o(status_we_o), .discard_o(discard_o), .pc_load_o(pc_load_o),
      .pc_target_o(pc_target_o), .stack_pop_i(stack_pop_i), .stack_top_o(stack_top_o));

   bosc_rf_model bosc_rf_model_inst (.clk_i(clk_i), .raddr_i(rf_raddr_o), .we_i(rf_we_o),
      .waddr_i(rf_waddr_o), .wdata_i(rf_wdata_o), .rdata_o(rf_rdata_i));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // *********************************************
   // checking
   // *********************************************
   task automatic check(input logic [25:0] g, input logic [25:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // outputs settle by the falling edge; one note per event, none left over
   always @(negedge clk_i) begin
      if (arst_n_i) begin
         check({25'd0, status_we_o}, 26'd0);
         if (discard_o === 1'b1) check({25'd0, instr_ready_o}, 26'd0);
         if (rf_we_o === 1'b1 || pc_load_o === 1'b1 || discard_o === 1'b1) begin
            if (rf_we_o === 1'b1) got = {2'd1, 11'd0, rf_waddr_o, rf_wdata_o};
            else if (pc_load_o === 1'b1) got = {2'd2, 1'b0, discard_o, pc_target_o, stack_top_o};
            else got = {2'd3, 24'd0};
            if (expq.size() == 0) check(got, 26'd0);
            else check(got, expq.pop_front());
         end
      end
   end

   // *********************************************
   // stimulus
   // *********************************************
   task automatic issue(input logic [INSTR_W-1:0] w);
      logic [PC_W-1:0]    p;
      logic [DATA_W-1:0]  st;
      logic [BIT_W-1:0]   b;
      logic [FADDR_W-1:0] f;
      int                 k;
      p = PC_W'($urandom);
      st = DATA_W'($urandom);
      b = w[BIT_LSB +: BIT_W];
      f = w[FADDR_LSB +: FADDR_W];
      instr_i <= w;
      pc_i <= p;
      status_i <= st;
      instr_valid_i <= 1'b1;
      case (w[OPC_LSB +: OPC_W])
         OPC_BIT_SET: begin
            shadow[f][b] = 1'b1;
            expq.push_back({2'd1, 11'd0, f, shadow[f]});
         end
         OPC_SKIP_ONE: if (shadow[f][b]) expq.push_back({2'd3, 24'd0});
         OPC_SKIP_ZERO: if (!shadow[f][b]) expq.push_back({2'd3, 24'd0});
         OPC_CALL: begin
            expq.push_back({2'd2, 1'b0, 1'b1, st[6:5], 1'b0, w[7:0], p + 11'd1});
            ret_old = ret_new;
            ret_new = p + 11'd1;
         end
         default: ;
      endcase
      @(negedge clk_i);
      k = 0;
      while (instr_ready_o !== 1'b1 && k < 10) begin
         @(negedge clk_i);
         k++;
      end
      // a slot that never ends counts as a mismatch
      if (k == 10) begin
         errors++;
         $display("BAD %0t ready never returned", $time);
      end
      @(posedge clk_i);
      // a write lands one edge late, so a gap keeps the next read honest
      if (w[OPC_LSB +: OPC_W] == OPC_BIT_SET || $urandom_range(3, 0) == 0) begin
         instr_valid_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   initial begin
      void'($urandom(32'h4542f631));
      for (int i = 0; i < 32; i++) begin
         shadow[i] = DATA_W'($urandom);
         bosc_rf_model_inst.mem[i] = shadow[i];
      end
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int n = 0; n < 300; n++) begin
         issue({opc_tab[$urandom_range(4, 0)], 8'($urandom)});
      end
      instr_valid_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(26'(expq.size()), 26'd0);
      // one pop brings the older return address to the top
      @(posedge clk_i);
      stack_pop_i <= 1'b1;
      @(posedge clk_i);
      stack_pop_i <= 1'b0;
      @(negedge clk_i);
      check({15'd0, stack_top_o}, {15'd0, ret_old});
      results();
   end

   initial begin
      #(25 * 5000);
      errors++;
      results();
   end
endmodule
